/* File: hdl/dpot_i2c_regs.v */
// serial target engine and register file of a quad digital potentiometer
`timescale 1ns/1ps
`include "dpot_consts.vh"
// Overview of operation
// - data changes only while clock low; high-clock changes mean start or stop
// - data line released after power-up until a response is due
// - watch for start (data falls, clock high); ignore bus until then
// - start conditions ignored while power-up sequence runs
// - every transfer ends with stop; stop returns engine to standby
// - transmitter releases after eight bits; receiver pulls low on ninth
// - acknowledge valid id byte, address byte and each written data byte
// - id byte is 1010, three pin bits, then read/write bit
// - write is start, id, address, data, stop, each byte acknowledged
// - extra write bytes go to next address; pointer wraps 8 to 0
// - non-volatile write starts only at stop; lasts up to 20 ms
// - read is id(0), address, repeated start, id(1), all acknowledged
// - keep sending while controller acknowledges; it ends with stop
// - read pointer starts at address, advances per byte, wraps 8 to 0
// - volatile select bit picks wipers or initial stores for 0..3
// - wiper writes with volatile select 1, and access control writes, refused while pending flag set
// - with volatile select 0, stores are copied into matching wiper
// - 4..6 general purpose non-volatile, 7 reserved, 8 access control
module dpot_i2c_regs
#(
    parameter NVW_CYCLES = `DPOT_NVW_CYCLES
)
(
    input wire MCLK,
    input wire RST,
    input wire SCL_IN,
    input wire SDA_IN,
    output wire SDA_OUT,
    output wire SDA_OE_N,
    input wire ADDR_PIN_BIT2,
    input wire ADDR_PIN_BIT1,
    input wire ADDR_PIN_BIT0,
    output reg [31:0] WIPER_OUT,
    output reg SHDN_BIT_OUT,
    output reg NV_WRITE_PENDING_FLAG,
    output reg VOLATILE_SELECT_BIT,
    output reg NV_COMMIT_PULSE
);
    localparam S_IDLE = 6'b000001;
    localparam S_ID = 6'b000010;
    localparam S_ADDR = 6'b000100;
    localparam S_WDATA = 6'b001000;
    localparam S_RDATA = 6'b010000;
    localparam S_RACK = 6'b100000;

    // pins pass three flops; a change counts when stages two and three agree
    reg [2:0] scl_sync_ff;
    reg [2:0] sda_sync_ff;
    reg scl_ff;
    reg sda_ff;
    reg [4:0] pup_cnt_ff;
    reg pup_done_ff;
    reg [5:0] state_ff;
    reg [3:0] bit_cnt_ff;
    reg [7:0] shift_ff;
    reg ack_phase_ff;
    reg drive_low_ff;
    reg [3:0] ptr_ff;
    reg rd_mode_ff;
    reg nv_dirty_ff;
    reg [31:0] nv_cnt_ff;
    reg [7:0] wiper_ff [0:3];
    reg [7:0] store_ff [0:6];
    reg [7:0] acr_ctl_ff;
    // two-entry write buffer between the serial side and the register file
    reg [11:0] buf_data_ff [0:1];
    reg buf_wr_ff;
    reg buf_rd_ff;
    reg [1:0] buf_cnt_ff;
    wire buf_in_valid;
    wire buf_in_ready;
    wire buf_out_valid;
    wire buf_out_ready;
    wire [11:0] buf_out_data;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;
    wire id_match;
    reg [7:0] rd_byte;
    integer i;

    function [3:0] dpot_next_ptr;
        input [3:0] p;
        begin
            dpot_next_ptr = (p >= `DPOT_ADDR_LAST) ? 4'h0 : p + 4'h1;
        end
    endfunction

    assign scl_rise = (scl_sync_ff[2] == scl_sync_ff[1]) && scl_sync_ff[1] && !scl_ff;
    assign scl_fall = (scl_sync_ff[2] == scl_sync_ff[1]) && !scl_sync_ff[1] && scl_ff;
    assign start_det = scl_ff && (sda_sync_ff[2] == sda_sync_ff[1]) && !sda_sync_ff[1]
        && sda_ff && pup_done_ff;
    assign stop_det = scl_ff && (sda_sync_ff[2] == sda_sync_ff[1]) && sda_sync_ff[1]
        && !sda_ff;
    assign id_match = (shift_ff[7:4] == `DPOT_ID_PREFIX)
        && (shift_ff[3:1] == {ADDR_PIN_BIT2, ADDR_PIN_BIT1, ADDR_PIN_BIT0});
    // open drain: only ever pull low, enable active low
    assign SDA_OUT = 1'b0;
    assign SDA_OE_N = !drive_low_ff;

    always @*
    begin
        rd_byte = 8'h00;
        if (ptr_ff < `DPOT_ADDR_GP_FIRST)
        begin
            if (acr_ctl_ff[`DPOT_ACR_VOL])
                rd_byte = wiper_ff[ptr_ff[1:0]];
            else
                rd_byte = store_ff[ptr_ff[2:0]];
        end
        else if (ptr_ff <= `DPOT_ADDR_GP_LAST)
            rd_byte = store_ff[ptr_ff[2:0]];
        else if (ptr_ff == `DPOT_ADDR_ACR)
            rd_byte = {acr_ctl_ff[7:6], NV_WRITE_PENDING_FLAG, 5'h00};
    end

    // synchronisers and power-up hold-off
    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            scl_sync_ff <= 3'h7;
            sda_sync_ff <= 3'h7;
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
            pup_cnt_ff <= 5'h00;
            pup_done_ff <= 1'b0;
        end
        else
        begin
            scl_sync_ff <= {scl_sync_ff[1:0], SCL_IN};
            sda_sync_ff <= {sda_sync_ff[1:0], SDA_IN};
            if (scl_sync_ff[2] == scl_sync_ff[1])
                scl_ff <= scl_sync_ff[1];
            if (sda_sync_ff[2] == sda_sync_ff[1])
                sda_ff <= sda_sync_ff[1];
            if (!pup_done_ff)
            begin
                pup_cnt_ff <= pup_cnt_ff + 5'h01;
                if (pup_cnt_ff == `DPOT_PUP_CYCLES - 1)
                    pup_done_ff <= 1'b1;
            end
        end
    end

    // buffer push happens on the ack of a received data byte
    assign buf_in_valid = (state_ff == S_WDATA) && scl_fall && (bit_cnt_ff == 4'h8)
        && !ack_phase_ff;
    assign buf_in_ready = (buf_cnt_ff != 2'h2);
    assign buf_out_valid = (buf_cnt_ff != 2'h0);
    // register file drains one word a cycle
    assign buf_out_ready = 1'b1;
    assign buf_out_data = buf_data_ff[buf_rd_ff];

    // serial engine
    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            state_ff <= S_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            ack_phase_ff <= 1'b0;
            drive_low_ff <= 1'b0;
            ptr_ff <= 4'h0;
            rd_mode_ff <= 1'b0;
        end
        else if (start_det)
        begin
            state_ff <= S_ID;
            bit_cnt_ff <= 4'h0;
            ack_phase_ff <= 1'b0;
            drive_low_ff <= 1'b0;
        end
        else if (stop_det)
        begin
            state_ff <= S_IDLE;
            drive_low_ff <= 1'b0;
        end
        else
        begin
            case (state_ff)
                S_IDLE:
                begin
                    drive_low_ff <= 1'b0;
                end
                S_ID, S_ADDR, S_WDATA:
                begin
                    if (scl_rise && !ack_phase_ff)
                    begin
                        shift_ff <= {shift_ff[6:0], sda_ff};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                    else if (scl_fall && ack_phase_ff)
                    begin
                        // ninth clock over: release and go on
                        ack_phase_ff <= 1'b0;
                        drive_low_ff <= 1'b0;
                        bit_cnt_ff <= 4'h0;
                        if (state_ff == S_ID)
                        begin
                            state_ff <= rd_mode_ff ? S_RDATA : S_ADDR;
                            if (rd_mode_ff)
                                drive_low_ff <= !rd_byte[7];
                            shift_ff <= rd_byte;
                        end
                        else if (state_ff == S_ADDR)
                            state_ff <= S_WDATA;
                    end
                    else if (scl_fall && bit_cnt_ff == 4'h8)
                    begin
                        if (state_ff == S_ID && !id_match)
                            state_ff <= S_IDLE;
                        else if (state_ff == S_WDATA && !buf_in_ready)
                            state_ff <= S_IDLE;
                        else
                        begin
                            ack_phase_ff <= 1'b1;
                            drive_low_ff <= 1'b1;
                            if (state_ff == S_ID)
                                rd_mode_ff <= shift_ff[0];
                            else if (state_ff == S_ADDR)
                                ptr_ff <= (shift_ff[3:0] > `DPOT_ADDR_LAST) ? 4'h0
                                    : shift_ff[3:0];
                            else
                                ptr_ff <= dpot_next_ptr(ptr_ff);
                        end
                    end
                end
                S_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_ff == 4'h7)
                        begin
                            drive_low_ff <= 1'b0;
                            state_ff <= S_RACK;
                            ptr_ff <= dpot_next_ptr(ptr_ff);
                        end
                        else
                        begin
                            drive_low_ff <= !shift_ff[6];
                            shift_ff <= {shift_ff[6:0], 1'b0};
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end
                    end
                end
                S_RACK:
                begin
                    if (scl_rise)
                    begin
                        // on ack stay here; the falling edge below loads the next byte
                        if (sda_ff)
                            state_ff <= S_IDLE;
                    end
                end
                default:
                begin
                    state_ff <= S_IDLE;
                end
            endcase
            if (state_ff == S_RACK && scl_fall)
            begin
                state_ff <= S_RDATA;
                bit_cnt_ff <= 4'h0;
                shift_ff <= rd_byte;
                drive_low_ff <= !rd_byte[7];
            end
        end
    end

    // buffer pointers; count changes by push minus pop
    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            buf_wr_ff <= 1'b0;
            buf_rd_ff <= 1'b0;
            buf_cnt_ff <= 2'h0;
            buf_data_ff[0] <= 12'h000;
            buf_data_ff[1] <= 12'h000;
        end
        else
        begin
            if (buf_in_valid && buf_in_ready)
            begin
                buf_data_ff[buf_wr_ff] <= {ptr_ff, shift_ff};
                buf_wr_ff <= !buf_wr_ff;
            end
            if (buf_out_valid && buf_out_ready)
                buf_rd_ff <= !buf_rd_ff;
            buf_cnt_ff <= buf_cnt_ff + {1'b0, buf_in_valid && buf_in_ready}
                - {1'b0, buf_out_valid && buf_out_ready};
        end
    end

    // register file and non-volatile timer
    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            for (i = 0; i < 4; i = i + 1)
                wiper_ff[i] <= `DPOT_WIPER_RESET;
            for (i = 0; i < 7; i = i + 1)
                store_ff[i] <= `DPOT_NV_RESET;
            acr_ctl_ff <= `DPOT_ACR_RESET;
            nv_dirty_ff <= 1'b0;
            nv_cnt_ff <= 32'h00000000;
            NV_WRITE_PENDING_FLAG <= 1'b0;
            NV_COMMIT_PULSE <= 1'b0;
        end
        else
        begin
            NV_COMMIT_PULSE <= 1'b0;
            if (buf_out_valid && buf_out_ready)
            begin
                if (buf_out_data[11:8] < `DPOT_ADDR_GP_FIRST)
                begin
                    if (acr_ctl_ff[`DPOT_ACR_VOL])
                    begin
                        if (!NV_WRITE_PENDING_FLAG)
                            wiper_ff[buf_out_data[9:8]] <= buf_out_data[7:0];
                    end
                    else
                    begin
                        store_ff[buf_out_data[10:8]] <= buf_out_data[7:0];
                        wiper_ff[buf_out_data[9:8]] <= buf_out_data[7:0];
                        nv_dirty_ff <= 1'b1;
                    end
                end
                else if (buf_out_data[11:8] <= `DPOT_ADDR_GP_LAST)
                begin
                    store_ff[buf_out_data[10:8]] <= buf_out_data[7:0];
                    nv_dirty_ff <= 1'b1;
                end
                else if (buf_out_data[11:8] == `DPOT_ADDR_ACR && !NV_WRITE_PENDING_FLAG)
                    acr_ctl_ff <= {buf_out_data[7:6], 6'h00};
            end
            if (stop_det && nv_dirty_ff)
            begin
                nv_dirty_ff <= 1'b0;
                NV_WRITE_PENDING_FLAG <= 1'b1;
                NV_COMMIT_PULSE <= 1'b1;
                nv_cnt_ff <= NVW_CYCLES - 1;
            end
            else if (NV_WRITE_PENDING_FLAG)
            begin
                if (nv_cnt_ff == 32'h00000000)
                    NV_WRITE_PENDING_FLAG <= 1'b0;
                else
                    nv_cnt_ff <= nv_cnt_ff - 32'h00000001;
            end
        end
    end

    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            WIPER_OUT <= {4{`DPOT_WIPER_RESET}};
            SHDN_BIT_OUT <= 1'b1;
            VOLATILE_SELECT_BIT <= 1'b0;
        end
        else
        begin
            WIPER_OUT <= {wiper_ff[3], wiper_ff[2], wiper_ff[1], wiper_ff[0]};
            SHDN_BIT_OUT <= acr_ctl_ff[`DPOT_ACR_SHDN];
            VOLATILE_SELECT_BIT <= acr_ctl_ff[`DPOT_ACR_VOL];
        end
    end
endmodule

/* File: hdl/dpot_consts.vh */
// constants for the potentiometer serial register engine
`ifndef DPOT_CONSTS_VH
`define DPOT_CONSTS_VH
`define DPOT_ID_PREFIX 4'ha
`define DPOT_ADDR_LAST 4'h8
`define DPOT_ADDR_GP_FIRST 4'h4
`define DPOT_ADDR_GP_LAST 4'h6
`define DPOT_ADDR_RSVD 4'h7
`define DPOT_ADDR_ACR 4'h8
`define DPOT_ACR_VOL 7
`define DPOT_ACR_SHDN 6
`define DPOT_ACR_WIP 5
`define DPOT_ACR_RESET 8'h40
`define DPOT_WIPER_RESET 8'h40
`define DPOT_NV_RESET 8'h40
`define DPOT_CLK_MHZ 125
`define DPOT_NVW_MS 20
`define DPOT_NVW_CYCLES (`DPOT_NVW_MS * 1000 * `DPOT_CLK_MHZ)
`define DPOT_PUP_CYCLES 16
`endif

/* File: dv/dpot_i2c_chk.sv */
// port assertions for the potentiometer serial engine
`timescale 1ns/1ps
module dpot_i2c_chk
#(
    parameter NVW_CYCLES = 200
)
(
    input wire MCLK,
    input wire RST,
    input wire SCL_IN,
    input wire SDA_IN,
    input wire SDA_OUT,
    input wire SDA_OE_N,
    input wire [31:0] WIPER_OUT,
    input wire SHDN_BIT_OUT,
    input wire NV_WRITE_PENDING_FLAG,
    input wire VOLATILE_SELECT_BIT,
    input wire NV_COMMIT_PULSE
);
    reg scl_d_ff;
    reg sda_d_ff;
    reg [3:0] since_stop_ff;
    reg [31:0] pend_len_ff;
    // raw pins are fine here: the bench moves them on clock edges only
    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            since_stop_ff <= 4'hf;
            pend_len_ff <= 32'h0;
        end
        else
        begin
            scl_d_ff <= SCL_IN;
            sda_d_ff <= SDA_IN;
            if (SCL_IN && scl_d_ff && SDA_IN && !sda_d_ff)
                since_stop_ff <= 4'h0;
            else if (since_stop_ff != 4'hf)
                since_stop_ff <= since_stop_ff + 4'h1;
            pend_len_ff <= NV_WRITE_PENDING_FLAG ? pend_len_ff + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);
    a_reset_state: assert property ($fell(RST) |-> SDA_OE_N && !NV_WRITE_PENDING_FLAG
        && WIPER_OUT == 32'h40404040 && !VOLATILE_SELECT_BIT && SHDN_BIT_OUT)
        else $error("state after reset wrong");
    a_drive_pulls: assert property (!SDA_OE_N |-> !SDA_OUT && !SDA_IN)
        else $error("driven data line not low");
    a_drive_scl_low: assert property ($changed(SDA_OE_N) |-> !SCL_IN)
        else $error("data drive moved while clock high");
    a_drive_span: assert property ($fell(SDA_OE_N) |-> !SDA_OE_N [*8])
        else $error("drive too short");
    a_commit_once: assert property (NV_COMMIT_PULSE |=> !NV_COMMIT_PULSE && NV_WRITE_PENDING_FLAG)
        else $error("commit pulse malformed");
    a_commit_stop: assert property (NV_COMMIT_PULSE |-> since_stop_ff < 4'hc)
        else $error("commit without stop");
    a_pend_cause: assert property ($rose(NV_WRITE_PENDING_FLAG) |->
        NV_COMMIT_PULSE || $past(NV_COMMIT_PULSE))
        else $error("pending without commit");
    a_pend_length: assert property ($fell(NV_WRITE_PENDING_FLAG) |->
        pend_len_ff >= NVW_CYCLES - 2 && pend_len_ff <= NVW_CYCLES + 2)
        else $error("pending length wrong");
    a_acr_locked: assert property ($changed({VOLATILE_SELECT_BIT, SHDN_BIT_OUT}) |->
        !$past(NV_WRITE_PENDING_FLAG))
        else $error("control bits changed while pending");
    a_wiper_locked: assert property ($changed(WIPER_OUT) |->
        !($past(NV_WRITE_PENDING_FLAG) && VOLATILE_SELECT_BIT))
        else $error("wiper changed while pending");
    c_commit: cover property (NV_COMMIT_PULSE);
    c_pend_done: cover property ($fell(NV_WRITE_PENDING_FLAG));
    c_vol_set: cover property ($rose(VOLATILE_SELECT_BIT));
endmodule
bind dpot_i2c_regs dpot_i2c_chk #(.NVW_CYCLES(NVW_CYCLES)) u_chk (.MCLK(MCLK), .RST(RST),
    .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
    .WIPER_OUT(WIPER_OUT), .SHDN_BIT_OUT(SHDN_BIT_OUT),
    .NV_WRITE_PENDING_FLAG(NV_WRITE_PENDING_FLAG),
    .VOLATILE_SELECT_BIT(VOLATILE_SELECT_BIT), .NV_COMMIT_PULSE(NV_COMMIT_PULSE));

/* File: dv/dpot_i2c_host.sv */
// bus controller model driving clock and open-drain data
`timescale 1ns/1ps
module dpot_i2c_host
(
    input wire mclk,
    input wire sda_in,
    output reg scl,
    output reg sda_drv
);
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // data moves late in the low phase, clear of the pin sync lag
    task automatic bitx(input logic b, output logic r);
        wt(4);
        sda_drv <= b;
        wt(2);
        scl <= 1'b1;
        wt(3);
        r = sda_in;
        wt(1);
        scl <= 1'b0;
    endtask
    task automatic start(input int n);
        wt(n);
        sda_drv <= 1'b1;
        wt(n);
        scl <= 1'b1;
        wt(4);
        sda_drv <= 1'b0;
        wt(4);
        scl <= 1'b0;
    endtask
    // clock then stays high: the link is still between frames
    task automatic stop();
        wt(4);
        sda_drv <= 1'b0;
        wt(4);
        scl <= 1'b1;
        wt(4);
        sda_drv <= 1'b1;
        wt(4);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(d[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(!more, r);
    endtask
endmodule

/* File: dv/testbench.sv */
// self-checking bench for the potentiometer serial engine
`timescale 1ns/1ps
module testbench;
    localparam int NVW = 2000;
    localparam logic [2:0] PINS = 3'b101;
    localparam logic [7:0] ID_W = {4'ha, PINS, 1'b0};
    logic mclk;
    logic rst;
    wire scl;
    wire sda_drv;
    wire sda;
    wire sda_out;
    wire sda_oe_n;
    wire [31:0] wiper;
    wire shdn;
    wire pend;
    wire volatile_select_bit;
    int fail_count = 0;
    int checked = 0;
    // open drain with pull-up: released means high
    assign sda = sda_drv & (sda_oe_n | sda_out);
    dpot_i2c_regs #(.NVW_CYCLES(NVW)) dut (.MCLK(mclk), .RST(rst), .SCL_IN(scl),
        .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .ADDR_PIN_BIT2(PINS[2]),
        .ADDR_PIN_BIT1(PINS[1]), .ADDR_PIN_BIT0(PINS[0]), .WIPER_OUT(wiper),
        .SHDN_BIT_OUT(shdn), .NV_WRITE_PENDING_FLAG(pend), .VOLATILE_SELECT_BIT(volatile_select_bit),
        .NV_COMMIT_PULSE());
    dpot_i2c_host u_host (.mclk(mclk), .sda_in(sda), .scl(scl), .sda_drv(sda_drv));
    task automatic results();
        if (fail_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
        logic k;
        u_host.start(4);
        u_host.wbyte(ID_W, k);
        cmp("id ack", 1, k);
        u_host.wbyte(a, k);
        cmp("addr ack", 1, k);
        foreach (d[i])
        begin
            u_host.wbyte(d[i], k);
            cmp("data ack", 1, k);
        end
        u_host.stop();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e[$]);
        logic k;
        logic [7:0] d;
        u_host.start(4);
        u_host.wbyte(ID_W, k);
        u_host.wbyte(a, k);
        u_host.start(4);
        u_host.wbyte(ID_W | 8'h01, k);
        cmp("read id ack", 1, k);
        foreach (e[i])
        begin
            u_host.rbyte(i < e.size() - 1, d);
            cmp("read data", e[i], d);
        end
        u_host.stop();
    endtask
    task automatic wait_pend(input logic lvl, input int n);
        for (int i = 0; i < n && pend !== lvl; i++)
            @(posedge mclk);
        cmp("pending", lvl, pend);
    endtask
    task automatic t_reset();
        logic k;
        cmp("wipers", 32'h40404040, wiper);
        cmp("vol shdn pend", 3'b010, {volatile_select_bit, shdn, pend});
        cmp("released", 1, sda_oe_n);
        u_host.start(1);
        u_host.wbyte(ID_W, k);
        cmp("early ack", 0, k);
        u_host.stop();
    endtask
    task automatic t_badid();
        logic k;
        u_host.start(4);
        u_host.wbyte({4'ha, ~PINS, 1'b0}, k);
        cmp("foreign id ack", 0, k);
        u_host.wbyte(ID_W, k);
        cmp("no start ack", 0, k);
        u_host.stop();
    endtask
    task automatic t_store();
        wr(8'h02, '{8'h33});
        wait_pend(1, 20);
        cmp("wiper copy", 8'h33, wiper[23:16]);
        rd(8'h08, '{8'h60});
        wr(8'h08, '{8'hc0});
        cmp("vol locked", 0, volatile_select_bit);
        wait_pend(0, NVW + 200);
        rd(8'h02, '{8'h33, 8'h40});
    endtask
    task automatic t_burst();
        wr(8'h07, '{8'h99, 8'hc0, 8'h11, 8'h22});
        repeat (30) @(posedge mclk);
        cmp("wipers", 32'h40332211, wiper);
        cmp("vol", 1, volatile_select_bit);
        cmp("no commit", 0, pend);
        rd(8'h07, '{8'h00, 8'hc0, 8'h11, 8'h22});
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        results();
    end
    initial
    begin
        rst = 1'b1;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_badid();
        t_store();
        t_burst();
        results();
    end
endmodule
